// ---- pkg/pxt_pkg.sv ----
// Package: register map, field layout and reset values of the extended page 2 bank
`default_nettype none

package pxt_pkg;

    // ==========================================================
    // Management register indices (byte address is index times four)
    localparam logic [4:0]  PXT_IDX_TX_AMPLITUDE_TRIM   = 5'h10;
    localparam logic [4:0]  PXT_IDX_EEE_DEBUG_CONTROL   = 5'h11;
    localparam logic [4:0]  PXT_IDX_PAGE_SELECT         = 5'h1F;
    localparam logic [4:0]  PXT_IDX_FIRST_PAGED         = 5'h10;
    localparam logic [15:0] PXT_PAGE_STANDARD           = 16'h0000;
    localparam logic [15:0] PXT_PAGE_EXT2               = 16'h0002;

    // ==========================================================
    // Field positions of the energy-efficient debug control register
    localparam int PXT_BIT_TE_ENABLE      = 15;
    localparam int PXT_BIT_LED_FIBER_UNI  = 14;
    localparam int PXT_BIT_LED_INV_LO     = 10;
    localparam int PXT_BIT_LINK_UP        = 8;
    localparam int PXT_BIT_EEE_1000       = 7;
    localparam int PXT_BIT_EEE_100        = 6;
    localparam int PXT_BIT_FORCE_GIG      = 5;
    localparam int PXT_BIT_FORCE_LPI      = 4;
    localparam int PXT_BIT_INH_TX_100     = 3;
    localparam int PXT_BIT_INH_RX_100     = 2;
    localparam int PXT_BIT_INH_TX_1000    = 1;
    localparam int PXT_BIT_INH_RX_1000    = 0;

    // ==========================================================
    // Reset values
    localparam logic [3:0]  PXT_RST_TRIM_1000  = 4'h0;
    localparam logic [3:0]  PXT_RST_TRIM_100   = 4'h2;
    localparam logic [3:0]  PXT_RST_TRIM_10    = 4'hB;
    localparam logic [3:0]  PXT_RST_TRIM_10E   = 4'hE;
    localparam logic [15:0] PXT_RST_EEE_CTRL   = 16'h0000;
    localparam logic [1:0]  PXT_FORCE_GIG_SPD  = 2'b10;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [3:0] t1000;
        logic [3:0] t100;
        logic [3:0] t10;
        logic [3:0] t10e;
    } pxt_trim_t;

    typedef enum logic [1:0] {
        PXT_SPD_10   = 2'b00,
        PXT_SPD_100  = 2'b01,
        PXT_SPD_1000 = 2'b10
    } pxt_speed_t;

    typedef struct packed {
        logic mac_tx_lpi;
        logic line_rx_lpi;
    } pxt_lpi_t;

endpackage : pxt_pkg

`default_nettype wire

// ---- design/pxt_page2_bank.sv ----
// Extended page 2 register bank with APB access, trim outputs and LPI steering
//
// The APB register port was left to the implementer.
`default_nettype none

module pxt_page2_bank (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Standard register space outside this bank
    output logic                    std_sel_o,
    output logic                    std_write_o,
    output logic      [4:0]         std_addr_o,
    output logic      [15:0]        std_wdata_o,
    input  wire logic [15:0]        std_rdata_i,
    input  wire logic               std_ready_i,
    input  wire logic [1:0]         std_speed_sel_i,
    // Port state
    input  wire logic               port_soft_reset_i,
    input  wire logic               link_up_i,
    input  wire logic               eee_1000_en_i,
    input  wire logic               eee_100_en_i,
    input  wire pxt_pkg::pxt_speed_t speed_i,
    input  wire logic               fiber_unidir_i,
    input  wire logic [15:0]        led_raw_i,
    input  wire pxt_pkg::pxt_lpi_t  lpi_in_i,
    // Outputs to the analogue and datapath
    output pxt_pkg::pxt_trim_t      copper_line_driver_trim_o,
    output logic                    te_mode_en_o,
    output logic                    force_gig_o,
    output logic                    test_packet_generator_lpi_o,
    output logic                    mac_data_ignore_o,
    output logic                    line_tx_lpi_o,
    output logic                    mac_rx_lpi_o,
    output logic      [15:0]        indicator_outputs_o
);
    import pxt_pkg::*;

    // ==========================================================
    // Storage
    pxt_trim_t   trim_q, trim_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] page_q, page_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  link_sync_q, e1000_sync_q, e100_sync_q;
    logic [15:0] leds_q;
    logic        line_tx_lpi_q;
    logic        mac_rx_lpi_q;

    // ==========================================================
    // Address decode
    wire logic [4:0] idx        = paddr[6:2];
    wire logic       in_range   = (paddr[7] == 1'b0);
    wire logic       page2      = (page_q == PXT_PAGE_EXT2);
    wire logic       paged_idx  = (idx >= PXT_IDX_FIRST_PAGED) &&
                                  (idx != PXT_IDX_PAGE_SELECT);
    wire logic       hit_page   = in_range && (idx == PXT_IDX_PAGE_SELECT);
    wire logic       hit_local  = in_range && page2 && paged_idx;
    wire logic       hit_std    = in_range && !hit_page && !hit_local;
    wire logic       hit_trim   = hit_local && (idx == PXT_IDX_TX_AMPLITUDE_TRIM);
    wire logic       hit_ctrl   = hit_local && (idx == PXT_IDX_EEE_DEBUG_CONTROL);
    wire logic       setup      = psel && !penable;
    wire logic       access     = psel && penable;

    // Standard space requests go out only during the access phase
    assign std_sel_o   = access && hit_std;
    assign std_write_o = pwrite;
    assign std_addr_o  = idx;
    assign std_wdata_o = pwdata[15:0];

    // Local answers come with no wait; standard space waits for its ready
    assign pready  = (access && hit_std) ? std_ready_i : 1'b1;
    assign pslverr = access && !in_range;
    assign prdata  = (access && hit_std) ? {16'h0000, std_rdata_i} : rdata_q;

    wire logic wr_en = access && pready && pwrite && in_range;

    // ==========================================================
    // Status synchronisers; these come from other clock regions of the port
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link_sync_q  <= 2'b00;
            e1000_sync_q <= 2'b00;
            e100_sync_q  <= 2'b00;
        end else begin
            link_sync_q  <= {link_sync_q[0], link_up_i};
            e1000_sync_q <= {e1000_sync_q[0], eee_1000_en_i};
            e100_sync_q  <= {e100_sync_q[0], eee_100_en_i};
        end
    end

    // ==========================================================
    // Read view of the control register: RO status overlays, bit 9 reads zero
    logic [15:0] ctrl_view;
    always_comb begin
        ctrl_view                    = ctrl_q;
        ctrl_view[9]                 = 1'b0;
        ctrl_view[PXT_BIT_LINK_UP]   = link_sync_q[1];
        ctrl_view[PXT_BIT_EEE_1000]  = e1000_sync_q[1];
        ctrl_view[PXT_BIT_EEE_100]   = e100_sync_q[1];
    end

    // Local read data is fetched in the setup cycle so it leaves a flip-flop
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            if (hit_trim) begin
                rdata_d = {16'h0000, trim_q};
            end else if (hit_ctrl) begin
                rdata_d = {16'h0000, ctrl_view};
            end else if (hit_page) begin
                rdata_d = {16'h0000, page_q};
            end
        end
    end

    // ==========================================================
    // Next values: trims are plain and fall back on soft reset, sticky bits do not
    localparam logic [15:0] CTRL_RW_MASK = 16'hFC3F;
    always_comb begin
        trim_d = trim_q;
        ctrl_d = ctrl_q;
        page_d = page_q;
        if (port_soft_reset_i) begin
            trim_d = '{PXT_RST_TRIM_1000, PXT_RST_TRIM_100,
                       PXT_RST_TRIM_10, PXT_RST_TRIM_10E};
        end else if (wr_en && hit_trim) begin
            trim_d = pwdata[15:0];
        end
        if (wr_en && hit_ctrl) begin
            ctrl_d = pwdata[15:0] & CTRL_RW_MASK;
        end
        if (wr_en && hit_page) begin
            page_d = pwdata[15:0];
        end
    end

    // Hardware reset alone clears the sticky bits and page select
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            trim_q  <= '{PXT_RST_TRIM_1000, PXT_RST_TRIM_100,
                         PXT_RST_TRIM_10, PXT_RST_TRIM_10E};
            ctrl_q  <= PXT_RST_EEE_CTRL;
            page_q  <= PXT_PAGE_STANDARD;
            rdata_q <= 32'h0000_0000;
        end else begin
            trim_q  <= trim_d;
            ctrl_q  <= ctrl_d;
            page_q  <= page_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Static controls
    assign copper_line_driver_trim_o = trim_q;
    assign te_mode_en_o              = ctrl_q[PXT_BIT_TE_ENABLE];
    assign force_gig_o = ctrl_q[PXT_BIT_FORCE_GIG] &&
                         (std_speed_sel_i == PXT_FORCE_GIG_SPD);
    assign test_packet_generator_lpi_o = ctrl_q[PXT_BIT_FORCE_LPI];
    assign mac_data_ignore_o           = ctrl_q[PXT_BIT_FORCE_LPI];

    // ==========================================================
    // LPI steering; the inhibit bits act only at their own speed
    wire logic inh_tx = (speed_i == PXT_SPD_100  && ctrl_q[PXT_BIT_INH_TX_100]) ||
                        (speed_i == PXT_SPD_1000 && ctrl_q[PXT_BIT_INH_TX_1000]);
    wire logic inh_rx = (speed_i == PXT_SPD_100  && ctrl_q[PXT_BIT_INH_RX_100]) ||
                        (speed_i == PXT_SPD_1000 && ctrl_q[PXT_BIT_INH_RX_1000]);
    wire logic tx_lpi_d = ctrl_q[PXT_BIT_FORCE_LPI] ? 1'b1 :
                          (lpi_in_i.mac_tx_lpi && !inh_tx);
    wire logic rx_lpi_d = lpi_in_i.line_rx_lpi && !inh_rx;

    // ==========================================================
    // Indicator drive: active low unless a group is inverted; fiber
    // unidirectional mode blanks them unless enabled
    logic [15:0] led_d;
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            led_d[g*4 +: 4] = ~led_raw_i[g*4 +: 4] ^
                              {4{ctrl_q[PXT_BIT_LED_INV_LO + g]}};
            if (fiber_unidir_i && !ctrl_q[PXT_BIT_LED_FIBER_UNI]) begin
                led_d[g*4 +: 4] = {4{ctrl_q[PXT_BIT_LED_INV_LO + g]}} ^ 4'hF;
            end
        end
    end

    // Datapath outputs leave flip-flops, one cycle behind their inputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            line_tx_lpi_q <= 1'b0;
            mac_rx_lpi_q  <= 1'b0;
            leds_q        <= 16'hFFFF;
        end else begin
            line_tx_lpi_q <= tx_lpi_d;
            mac_rx_lpi_q  <= rx_lpi_d;
            leds_q        <= led_d;
        end
    end

    assign line_tx_lpi_o       = line_tx_lpi_q;
    assign mac_rx_lpi_o        = mac_rx_lpi_q;
    assign indicator_outputs_o = leds_q;

    // ==========================================================
    // Assertions
    a_page_select_enter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && hit_page && pwdata[15:0] == 16'h0002) |=> page2)
        else $error("page 2 not entered after select write");

    a_page_route_hi: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && page2 && in_range && idx >= 5'd16 && idx <= 5'd30)
        |-> !std_sel_o)
        else $error("paged address leaked to standard space");

    a_low_addr_std: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && in_range && idx < 5'd16) |-> std_sel_o)
        else $error("low address not routed to standard space");

    a_page_select_leave: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && hit_page && pwdata[15:0] == 16'h0000)
        |=> (!page2 && page_q == 16'h0000))
        else $error("page 2 not left after zero write");

    a_trim_write_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && hit_trim && !port_soft_reset_i)
        |=> copper_line_driver_trim_o == $past(pwdata[15:0]))
        else $error("trim write not driven to line driver");

    a_trim_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (setup && hit_trim) ##1 (access && pready) |-> prdata[15:0] == trim_q)
        else $error("trim readback mismatch");

    a_te_enable_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && hit_ctrl) |=> te_mode_en_o == $past(pwdata[15]))
        else $error("10BASE-Te enable not following write");

    a_led_fiber_blank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fiber_unidir_i && !ctrl_q[14] && ctrl_q[13:10] == 4'h0 && $stable(ctrl_q))
        |=> indicator_outputs_o == 16'hFFFF)
        else $error("indicators not blanked in fiber unidirectional mode");

    a_led_polarity: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!fiber_unidir_i && ctrl_q[13:10] == 4'h0 && $stable(ctrl_q))
        |=> indicator_outputs_o == ~$past(led_raw_i))
        else $error("indicators not active low by default");

    a_eee_status_1000: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(e1000_sync_q[1]) |-> $past(eee_1000_en_i, 2))
        else $error("gigabit EEE status without cause");

    a_eee_status_100: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (setup && hit_ctrl) |=> rdata_q[6] == $past(e100_sync_q[1]))
        else $error("100BASE-TX EEE status wrong in readback");

    a_force_gig_cond: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        force_gig_o |-> (ctrl_q[5] && std_speed_sel_i == 2'b10))
        else $error("forced gigabit without enable and speed bits");

    a_force_lpi_tx: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctrl_q[4] [*2] |-> (line_tx_lpi_o && mac_data_ignore_o))
        else $error("forced LPI not transmitted");

    a_idle_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!ctrl_q[4] && (speed_i == PXT_SPD_10 || ctrl_q[3:0] == 4'h0))
        |=> line_tx_lpi_o == $past(lpi_in_i.mac_tx_lpi))
        else $error("MAC idle not passed unchanged");

    a_inh_tx_100: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!ctrl_q[4] && ctrl_q[3] && speed_i == PXT_SPD_100) |=> !line_tx_lpi_o)
        else $error("100BASE-TX transmit LPI not inhibited");

    a_inh_rx_100: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ctrl_q[2] && speed_i == PXT_SPD_100) |=> !mac_rx_lpi_o)
        else $error("100BASE-TX receive LPI not inhibited");

    a_inh_tx_1000: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!ctrl_q[4] && ctrl_q[1] && speed_i == PXT_SPD_1000) |=> !line_tx_lpi_o)
        else $error("gigabit transmit LPI not inhibited");

    a_inh_rx_1000: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ctrl_q[0] && speed_i == PXT_SPD_1000) |=> !mac_rx_lpi_o)
        else $error("gigabit receive LPI not inhibited");

    a_link_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        link_up_i [*3] |-> ctrl_view[8])
        else $error("link status not reflected");

    a_sticky_soft_rst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (port_soft_reset_i && !(wr_en && hit_ctrl))
        |=> (ctrl_q == $past(ctrl_q) && trim_q == 16'h02BE))
        else $error("soft reset disturbed sticky bits or missed trims");

endmodule : pxt_page2_bank

`default_nettype wire

// ---- testbench/pxt_std_model.sv ----
// Behavioural model of the standard management register space behind the bank
`default_nettype none

module pxt_std_model #(
    parameter int WAITS = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sel_i,
    input  wire logic        write_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] mem_q [32];
    logic [15:0] last_q;
    logic [1:0]  cnt_q;

    // ==========================================================
    // Answer after WAITS cycles; a deselected bus shows the inverse of the last value
    assign ready_o = sel_i && (cnt_q == 2'(WAITS));
    assign rdata_o = sel_i ? mem_q[addr_i] : ~last_q;

    // Each register starts as A5 in the high byte and its index below
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 2'h0;
            last_q <= 16'h0000;
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= 16'hA500 | 16'(i);
            end
        end else if (sel_i && ready_o) begin
            cnt_q  <= 2'h0;
            last_q <= mem_q[addr_i];
            if (write_i) begin
                mem_q[addr_i] <= wdata_i;
            end
        end else begin
            cnt_q <= sel_i ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule : pxt_std_model

`default_nettype wire

// ---- testbench/phy_ext_page2_tx_trim_eee_ctrl_tb_top.sv ----
// Self-checking bench for the extended page 2 register bank
`default_nettype none

module phy_ext_page2_tx_trim_eee_ctrl_tb_top;
    import pxt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic std_sel, std_wr, std_rdy, soft_rst, link_up, eee_1000, eee_100, fiber;
    logic [4:0]  std_addr;
    logic [15:0] std_wdata, std_rdata, led_raw, ind;
    logic [1:0]  spd_sel;
    pxt_speed_t  speed;
    pxt_lpi_t    lpi_in;
    pxt_trim_t   trim;
    logic te_en, force_gig, gen_lpi, mac_ign, tx_lpi, rx_lpi;
    int n_fail, tests_run;

    pxt_page2_bank pxt_page2_bank_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .std_sel_o(std_sel),
        .std_write_o(std_wr), .std_addr_o(std_addr), .std_wdata_o(std_wdata),
        .std_rdata_i(std_rdata), .std_ready_i(std_rdy), .std_speed_sel_i(spd_sel),
        .port_soft_reset_i(soft_rst), .link_up_i(link_up), .eee_1000_en_i(eee_1000),
        .eee_100_en_i(eee_100), .speed_i(speed), .fiber_unidir_i(fiber),
        .led_raw_i(led_raw), .lpi_in_i(lpi_in), .copper_line_driver_trim_o(trim),
        .te_mode_en_o(te_en), .force_gig_o(force_gig),
        .test_packet_generator_lpi_o(gen_lpi), .mac_data_ignore_o(mac_ign),
        .line_tx_lpi_o(tx_lpi), .mac_rx_lpi_o(rx_lpi), .indicator_outputs_o(ind)
    );

    pxt_std_model #(.WAITS(2)) pxt_std_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sel_i(std_sel), .write_i(std_wr),
        .addr_i(std_addr), .wdata_i(std_wdata), .rdata_o(std_rdata), .ready_o(std_rdy)
    );

    // ==========================================================
    // Clock and watchdog; a hang ends through the same closing task
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end

    // ==========================================================
    // Tasks
    task automatic wrap_up();
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Request held until pready is seen high at a rising edge; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk

    // Registered outputs lag their inputs by up to two edges
    task automatic settle();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    task automatic lpi_case(input logic [15:0] c, input pxt_speed_t s,
                            input logic tx, input logic rx, input logic etx, input logic erx);
        apb(1'b1, 8'h44, {16'h0, c});
        @(posedge clk_i);
        speed  <= s;
        lpi_in <= pxt_lpi_t'{tx, rx};
        settle();
        chk_bit(tx_lpi, etx);
        chk_bit(rx_lpi, erx);
        chk_bit(gen_lpi, c[4]);
        chk_bit(mac_ign, c[4]);
    endtask : lpi_case

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n_i, psel, penable, pwrite, soft_rst, fiber, eee_100} = '0;
        {link_up, eee_1000} = 2'b11;
        paddr = 8'h0;
        pwdata = 32'h0;
        led_raw = 16'h0;
        spd_sel = 2'b00;
        speed = PXT_SPD_1000;
        lpi_in = pxt_lpi_t'(2'b00);
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rchk(8'h40, 32'h0000A510);
        chk_bit(err, 1'b0);
        chk_bit(te_en, 1'b0);
        apb(1'b1, 8'h7C, 32'h2);
        rchk(8'h40, 32'h000002BE);
        rchk(8'h44, 32'h00000180);
        rchk(8'h48, 32'h0);
        apb(1'b1, 8'h04, 32'h5A5A);
        rchk(8'h04, 32'h00005A5A);
        apb(1'b1, 8'h40, 32'h1234);
        settle();
        chk({16'h0, trim}, 32'h00001234);
        rchk(8'h80, 32'h0);
        chk_bit(err, 1'b1);
        apb(1'b1, 8'h44, 32'hFFFF);
        rchk(8'h44, 32'h0000FDBF);
        // Flip every status input so each read-only status bit is seen in both states
        @(posedge clk_i);
        eee_100  <= 1'b1;
        eee_1000 <= 1'b0;
        link_up  <= 1'b0;
        settle();
        rchk(8'h44, 32'h0000FC7F);
        @(posedge clk_i);
        eee_1000 <= 1'b1;
        link_up  <= 1'b1;
        eee_100  <= 1'b0;
        @(posedge clk_i);
        led_raw <= 16'h00A5;
        spd_sel <= 2'b10;
        settle();
        chk_bit(te_en, 1'b1);
        chk_bit(force_gig, 1'b1);
        chk({16'h0, ind}, 32'h000000A5);
        @(posedge clk_i);
        fiber <= 1'b1;
        spd_sel <= 2'b01;
        settle();
        chk({16'h0, ind}, 32'h000000A5);
        chk_bit(force_gig, 1'b0);
        @(posedge clk_i);
        soft_rst <= 1'b1;
        @(posedge clk_i);
        soft_rst <= 1'b0;
        rchk(8'h40, 32'h000002BE);
        rchk(8'h44, 32'h0000FDBF);
        apb(1'b1, 8'h44, 32'h0400);
        settle();
        chk({16'h0, ind}, 32'h0000FFF0);
        @(posedge clk_i);
        fiber <= 1'b0;
        settle();
        chk({16'h0, ind}, 32'h0000FF55);
        lpi_case(16'h0000, PXT_SPD_1000, 1'b1, 1'b1, 1'b1, 1'b1);
        lpi_case(16'h0008, PXT_SPD_100, 1'b1, 1'b1, 1'b0, 1'b1);
        lpi_case(16'h0004, PXT_SPD_100, 1'b1, 1'b1, 1'b1, 1'b0);
        lpi_case(16'h0002, PXT_SPD_1000, 1'b1, 1'b1, 1'b0, 1'b1);
        lpi_case(16'h0001, PXT_SPD_1000, 1'b1, 1'b1, 1'b1, 1'b0);
        lpi_case(16'h0008, PXT_SPD_1000, 1'b1, 1'b1, 1'b1, 1'b1);
        lpi_case(16'h0010, PXT_SPD_1000, 1'b0, 1'b0, 1'b1, 1'b0);
        lpi_case(16'h000F, PXT_SPD_10, 1'b1, 1'b1, 1'b1, 1'b1);
        lpi_case(16'h0000, PXT_SPD_1000, 1'b1, 1'b0, 1'b1, 1'b0);
        apb(1'b1, 8'h7C, 32'h0);
        rchk(8'h40, 32'h0000A510);
        wrap_up();
    end
endmodule : phy_ext_page2_tx_trim_eee_ctrl_tb_top

`default_nettype wire
